// *** logic/sink_pkg.sv ***
// Shared constants and types for the supervisory-unequipped container sink.
// Assumes a 50 MHz register clock and a bit-serial link slower than it.
`default_nettype none
package sink_pkg;
  // Frame layout: bytes counted from the V5 byte at frame start
  localparam int unsigned FRAME_BYTES = 104;
  localparam int unsigned V5_BYTE = 0;
  localparam int unsigned J2_BYTE = 26;
  localparam int unsigned TRACE_LEN = 16;
  localparam logic [2:0] PERSIST_FRAMES = 3'h5;
  // Timing
  localparam longint unsigned ONE_SECOND_NS = 64'd1000000000;
  localparam longint unsigned CLK_PERIOD_NS = 64'd20;
  localparam int unsigned SEC_CYCLES = int'(ONE_SECOND_NS / CLK_PERIOD_NS);
  // Register map (byte addresses)
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_DEG = 8'h04;
  localparam logic [7:0] REG_STATUS = 8'h08;
  localparam logic [7:0] REG_INT_STATUS = 8'h0C;
  localparam logic [7:0] REG_INT_MASK = 8'h10;
  localparam logic [7:0] REG_NEAR_COUNT = 8'h14;
  localparam logic [7:0] REG_FAR_COUNT = 8'h18;
  localparam logic [7:0] TRACE_ACC_BASE = 8'h40;
  localparam logic [7:0] TRACE_EXP_BASE = 8'h80;
  // Control fields
  localparam int unsigned CTRL_MONITOR_BIT = 0;
  localparam int unsigned CTRL_SSF_REP_BIT = 1;
  localparam int unsigned CTRL_RDI_REP_BIT = 2;
  localparam int unsigned CTRL_TIMDIS_BIT = 3;
  localparam int unsigned DEG_THR_LSB = 0;
  localparam int unsigned DEG_M_LSB = 16;
  localparam logic [3:0] CTRL_RESET = 4'h0;
  localparam logic [15:0] DEG_THR_RESET = 16'h0010;
  localparam logic [3:0] DEG_M_RESET = 4'h2;
  localparam logic [4:0] INT_MASK_RESET = 5'h00;
  // Event / defect / report bit order
  localparam int unsigned EV_TIM = 0;
  localparam int unsigned EV_UNEQ = 1;
  localparam int unsigned EV_DEG = 2;
  localparam int unsigned EV_RDI = 3;
  localparam int unsigned EV_SSF = 4;
  localparam int unsigned ST_TSF_BIT = 5;
  localparam int unsigned ST_AZERO_BIT = 6;
  localparam int unsigned ST_REI_LSB = 8;
  localparam int unsigned ST_REP_LSB = 16;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  typedef enum logic [1:0] {
    RD_IDLE = 2'h0,
    RD_MEM = 2'h1,
    RD_RESP = 2'h3
  } rd_state_t;
endpackage
`default_nettype wire

// *** logic/link_if.sv ***
// Recovered link bits handed from the sampler to the sink core.
// Assumes both ends run on aclk.
`default_nettype none
interface link_if;
  logic bit_stb;
  logic bit_d;
  logic frame_start;
  logic server_fail;
  modport src (output bit_stb, output bit_d, output frame_start,
    output server_fail);
  modport dst (input bit_stb, input bit_d, input frame_start,
    input server_fail);
endinterface
`default_nettype wire

// *** logic/link_sampler.sv ***
// Synchronises the link pins into aclk and marks each link clock rise.
// Assumes the link clock is slower than a quarter of aclk.
`default_nettype none
module link_sampler (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic ci_clk,
  input wire logic ci_data,
  input wire logic ci_frame_start,
  input wire logic server_fail,
  link_if.src lk
);
  typedef struct packed {
    logic [3:0] meta;
    logic [3:0] sync;
    logic ck_prev;
    logic stb;
    logic d;
    logic fs;
    logic ssf;
  } smp_t;
  smp_t s_q, s_d;

  always_comb
  begin
    s_d = s_q;
    s_d.meta = {ci_clk, ci_data, ci_frame_start, server_fail};
    s_d.sync = s_q.meta;
    s_d.ck_prev = s_q.sync[3];
    // Data is taken at the synced clock rise, mid-bit for the far end
    s_d.stb = s_q.sync[3] & ~s_q.ck_prev;
    s_d.d = s_q.sync[2];
    s_d.fs = s_q.sync[1];
    s_d.ssf = s_q.sync[0];
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      s_q <= '0;
    else
      s_q <= s_d;
  end

  assign lk.bit_stb = s_q.stb;
  assign lk.bit_d = s_q.d;
  assign lk.frame_start = s_q.fs;
  assign lk.server_fail = s_q.ssf;
endmodule
`default_nettype wire

// *** logic/trace_mem.sv ***
// Trace store: low half holds received trace, high half the expected one.
// Assumes the two write ports never hit the same half.
`default_nettype none
module trace_mem #(
  parameter int unsigned AW = 5
) (
  input wire logic aclk,
  input wire logic we_a,
  input wire logic [AW-1:0] wa_a,
  input wire logic [7:0] wd_a,
  input wire logic we_b,
  input wire logic [AW-1:0] wa_b,
  input wire logic [7:0] wd_b,
  input wire logic [AW-1:0] ra_a,
  output logic [7:0] rd_a,
  input wire logic [AW-1:0] ra_b,
  output logic [7:0] rd_b
);
  logic [7:0] mem [2**AW];

  always_ff @(posedge aclk)
  begin
    if (we_a)
      mem[wa_a] <= wd_a;
    if (we_b)
      mem[wa_b] <= wd_b;
    rd_a <= mem[ra_a];
    rd_b <= mem[ra_b];
  end
endmodule
`default_nettype wire

// *** logic/vc11_unequipped_sink.sv ***
// Sink trail termination for a supervisory-unequipped container.
// Assumes framed serial data MSB first, frame start on the V5 first bit.
`default_nettype none
module vc11_unequipped_sink #(
  parameter int unsigned SEC_CYCLES = sink_pkg::SEC_CYCLES
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic ci_clk,
  input wire logic ci_data,
  input wire logic ci_frame_start,
  input wire logic incoming_server_fail,
  input wire logic [7:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [7:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  output logic trail_fail_action,
  output logic trail_degrade_action,
  output logic remote_defect_action,
  output logic [1:0] remote_error_action,
  output logic reported_trace_mismatch,
  output logic reported_unequipped,
  output logic reported_degrade,
  output logic reported_far_defect,
  output logic reported_server_fail,
  output logic irq
);
  typedef struct packed {
    logic bvalid;
    logic [1:0] bresp;
    sink_pkg::rd_state_t rst;
    logic [5:0] ar_idx;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic [3:0] ctrl;
    logic [15:0] thr;
    logic [3:0] degm;
    logic [4:0] ist;
    logic [4:0] imask;
    logic [15:0] ncnt;
    logic [15:0] fcnt;
    logic [2:0] bitc;
    logic [6:0] bytec;
    logic [7:0] sh;
    logic [1:0] bip;
    logic bip_ok;
    logic [3:0] fidx;
    logic [1:0] rei;
    logic uneq;
    logic [2:0] uneq_cnt;
    logic rdi;
    logic [2:0] rdi_cnt;
    logic mism;
    logic nonzero;
    logic tim;
    logic azero;
    logic [31:0] sec;
    logic [15:0] ec;
    logic [3:0] run;
    logic deg;
    logic tsf;
    logic [4:0] rep;
  } state_t;
  state_t s_q, s_d;

  link_if lk ();
  logic [7:0] exp_byte;
  logic [7:0] bus_byte;
  logic [4:0] bus_ma;
  logic [7:0] nb;
  logic [2:0] bc;
  logic [6:0] bi;
  logic byte_done;
  logic [1:0] par;
  logic [1:0] diff;
  logic near_ev;
  logic far_ev;
  logic trace_we;
  logic exp_we;
  logic [5:0] w_idx;
  logic bad;
  logic [4:0] rep_new;
  logic rd_take;
  logic [5:0] ri;

  ////////////////////////////////////////////////////////////////////////////
  // Helpers

  // Returns {state, count}; five agreeing frames flip the state
  function automatic logic [3:0] persist(input logic state,
    input logic [2:0] cnt, input logic sample);
    logic [2:0] c;
    c = (sample != state) ? cnt + 3'h1 : 3'h0;
    if (c == sink_pkg::PERSIST_FRAMES)
      return {sample, 3'h0};
    return {state, c};
  endfunction

  function automatic logic mapped(input logic [5:0] idx);
    return idx <= sink_pkg::REG_FAR_COUNT[7:2] ||
      (idx >= sink_pkg::TRACE_ACC_BASE[7:2] &&
       idx < sink_pkg::TRACE_EXP_BASE[7:2] + 6'h10);
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Sub-blocks

  link_sampler u_smp (
    .aclk(aclk),
    .aresetn(aresetn),
    .ci_clk(ci_clk),
    .ci_data(ci_data),
    .ci_frame_start(ci_frame_start),
    .server_fail(incoming_server_fail),
    .lk(lk.src)
  );

  // Read of the expected byte at the current frame index is always ready
  trace_mem #(.AW(5)) u_mem (
    .aclk(aclk),
    .we_a(trace_we),
    .wa_a({1'b0, s_q.fidx}),
    .wd_a(nb),
    .we_b(exp_we),
    .wa_b({1'b1, w_idx[3:0]}),
    .wd_b(wdata[7:0]),
    .ra_a({1'b1, s_q.fidx}),
    .rd_a(exp_byte),
    .ra_b(bus_ma),
    .rd_b(bus_byte)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Next state

  always_comb
  begin
    s_d = s_q;
    nb = {s_q.sh[6:0], lk.bit_d};
    bc = lk.frame_start ? 3'h0 : s_q.bitc;
    bi = lk.frame_start ? 7'h00 : s_q.bytec;
    byte_done = lk.bit_stb && bc == 3'h7;
    par = {^(nb & 8'hAA), ^(nb & 8'h55)};
    diff = nb[7:6] ^ s_q.bip;
    near_ev = 1'b0;
    far_ev = 1'b0;
    trace_we = 1'b0;
    exp_we = 1'b0;
    w_idx = awaddr[7:2];
    bad = 1'b0;
    rep_new = '0;
    rd_take = 1'b0;
    ri = s_q.ar_idx;

    // Link framing
    if (lk.bit_stb)
    begin
      s_d.sh = nb;
      s_d.bitc = bc + 3'h1;
      s_d.bytec = bi;
    end
    if (byte_done)
    begin
      s_d.bytec = (bi == 7'(sink_pkg::FRAME_BYTES - 1)) ? 7'h00 : bi + 7'h01;
      if (bi == 7'(sink_pkg::V5_BYTE))
      begin
        if (s_q.bip_ok)
        begin
          near_ev = |diff;
          far_ev = nb[5];
          s_d.rei = {1'b0, diff[1]} + {1'b0, diff[0]};
        end
        // New frame parity starts with this V5 byte
        s_d.bip = par;
        s_d.bip_ok = 1'b1;
        {s_d.uneq, s_d.uneq_cnt} =
          persist(s_q.uneq, s_q.uneq_cnt, nb[3:1] == 3'h0);
        {s_d.rdi, s_d.rdi_cnt} =
          persist(s_q.rdi, s_q.rdi_cnt, nb[0]);
        s_d.fidx = s_q.fidx + 4'h1;
        if (s_q.fidx == 4'(sink_pkg::TRACE_LEN - 1))
        begin
          // Trace verdict once per full trace cycle
          s_d.tim = s_q.mism & ~s_q.ctrl[sink_pkg::CTRL_TIMDIS_BIT];
          s_d.azero = ~s_q.nonzero;
          s_d.mism = 1'b0;
          s_d.nonzero = 1'b0;
        end
      end
      else
      begin
        // K4 and all other bytes feed parity; J2 also feeds the trace store
        s_d.bip = s_q.bip ^ par;
        if (bi == 7'(sink_pkg::J2_BYTE))
        begin
          trace_we = 1'b1;
          s_d.mism = s_q.mism | (nb != exp_byte);
          s_d.nonzero = s_q.nonzero | (nb != 8'h00);
        end
      end
    end

    // Degrade over whole seconds
    if (near_ev)
      s_d.ec = s_q.ec + 16'h0001;
    if (s_q.sec == SEC_CYCLES - 1)
    begin
      s_d.sec = '0;
      s_d.ec = {15'h0000, near_ev};
      bad = s_q.thr != 16'h0000 && s_q.ec >= s_q.thr;
      if (bad == s_q.deg)
        s_d.run = 4'h0;
      else if (s_q.run + 4'h1 >= s_q.degm)
      begin
        s_d.deg = bad;
        s_d.run = 4'h0;
      end
      else
        s_d.run = s_q.run + 4'h1;
    end
    else
      s_d.sec = s_q.sec + 32'h1;

    // Actions: unequipped is deliberately left out
    s_d.tsf = lk.server_fail | s_q.tim;
    rep_new[sink_pkg::EV_TIM] = s_q.ctrl[sink_pkg::CTRL_MONITOR_BIT] &
      s_q.tim & ~(s_q.uneq & s_q.azero);
    rep_new[sink_pkg::EV_UNEQ] = s_q.ctrl[sink_pkg::CTRL_MONITOR_BIT] &
      s_q.tim & s_q.azero & s_q.uneq;
    rep_new[sink_pkg::EV_DEG] = s_q.ctrl[sink_pkg::CTRL_MONITOR_BIT] &
      ~s_q.tim & s_q.deg;
    rep_new[sink_pkg::EV_RDI] = s_q.ctrl[sink_pkg::CTRL_MONITOR_BIT] &
      ~s_q.tim & s_q.rdi & s_q.ctrl[sink_pkg::CTRL_RDI_REP_BIT];
    rep_new[sink_pkg::EV_SSF] = s_q.ctrl[sink_pkg::CTRL_MONITOR_BIT] &
      lk.server_fail & s_q.ctrl[sink_pkg::CTRL_SSF_REP_BIT];
    s_d.rep = rep_new;

    // Write channel: address and data taken together
    if (s_q.bvalid && bready)
      s_d.bvalid = 1'b0;
    if (awvalid && wvalid && !s_q.bvalid)
    begin
      s_d.bvalid = 1'b1;
      s_d.bresp = mapped(w_idx) ? sink_pkg::RESP_OKAY : sink_pkg::RESP_SLVERR;
      if (w_idx == sink_pkg::REG_CTRL[7:2] && wstrb[0])
        s_d.ctrl = wdata[3:0];
      if (w_idx == sink_pkg::REG_DEG[7:2])
      begin
        if (wstrb[0])
          s_d.thr[7:0] = wdata[7:0];
        if (wstrb[1])
          s_d.thr[15:8] = wdata[15:8];
        if (wstrb[2])
          s_d.degm = wdata[sink_pkg::DEG_M_LSB +: 4];
      end
      if (w_idx == sink_pkg::REG_INT_MASK[7:2] && wstrb[0])
        s_d.imask = wdata[4:0];
      exp_we = wstrb[0] && w_idx[5:4] == sink_pkg::TRACE_EXP_BASE[7:6];
    end

    // Read channel
    unique case (s_q.rst)
      sink_pkg::RD_IDLE:
      begin
        if (arvalid)
        begin
          s_d.ar_idx = araddr[7:2];
          s_d.rst = sink_pkg::RD_MEM;
        end
      end
      sink_pkg::RD_MEM:
      begin
        rd_take = 1'b1;
        s_d.rst = sink_pkg::RD_RESP;
        s_d.rresp = mapped(ri) ? sink_pkg::RESP_OKAY : sink_pkg::RESP_SLVERR;
        s_d.rdata = '0;
        if (ri[5:4] != 2'h0)
          s_d.rdata = mapped(ri) ? {24'h000000, bus_byte} : 32'h0;
        else if (ri == sink_pkg::REG_CTRL[7:2])
          s_d.rdata = {28'h0000000, s_q.ctrl};
        else if (ri == sink_pkg::REG_DEG[7:2])
          s_d.rdata = {12'h000, s_q.degm, s_q.thr};
        else if (ri == sink_pkg::REG_STATUS[7:2])
        begin
          s_d.rdata[4:0] = {lk.server_fail, s_q.rdi, s_q.deg, s_q.uneq,
            s_q.tim};
          s_d.rdata[sink_pkg::ST_TSF_BIT] = s_q.tsf;
          s_d.rdata[sink_pkg::ST_AZERO_BIT] = s_q.azero;
          s_d.rdata[sink_pkg::ST_REI_LSB +: 2] = s_q.rei;
          s_d.rdata[sink_pkg::ST_REP_LSB +: 5] = s_q.rep;
        end
        else if (ri == sink_pkg::REG_INT_STATUS[7:2])
        begin
          s_d.rdata = {27'h0000000, s_q.ist};
          s_d.ist = '0;
        end
        else if (ri == sink_pkg::REG_INT_MASK[7:2])
          s_d.rdata = {27'h0000000, s_q.imask};
        else if (ri == sink_pkg::REG_NEAR_COUNT[7:2])
        begin
          s_d.rdata = {16'h0000, s_q.ncnt};
          s_d.ncnt = '0;
        end
        else if (ri == sink_pkg::REG_FAR_COUNT[7:2])
        begin
          s_d.rdata = {16'h0000, s_q.fcnt};
          s_d.fcnt = '0;
        end
      end
      sink_pkg::RD_RESP:
      begin
        if (rready)
          s_d.rst = sink_pkg::RD_IDLE;
      end
      default:
        s_d.rst = sink_pkg::RD_IDLE;
    endcase

    // Counters and sticky flags: events win over a clear in the same cycle
    if (near_ev)
      s_d.ncnt = (rd_take && ri == sink_pkg::REG_NEAR_COUNT[7:2]) ?
        16'h0001 : s_q.ncnt + 16'h0001;
    if (far_ev)
      s_d.fcnt = (rd_take && ri == sink_pkg::REG_FAR_COUNT[7:2]) ?
        16'h0001 : s_q.fcnt + 16'h0001;
    s_d.ist = s_d.ist | (rep_new & ~s_q.rep);
  end

  // Memory read address is presented in the accept cycle so data lands next
  assign bus_ma = (s_q.rst == sink_pkg::RD_IDLE) ?
    {araddr[7], araddr[5:2]} : {s_q.ar_idx[5], s_q.ar_idx[3:0]};

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_q <= '0;
      s_q.rst <= sink_pkg::RD_IDLE;
      s_q.ctrl <= sink_pkg::CTRL_RESET;
      s_q.thr <= sink_pkg::DEG_THR_RESET;
      s_q.degm <= sink_pkg::DEG_M_RESET;
      s_q.imask <= sink_pkg::INT_MASK_RESET;
    end
    else
      s_q <= s_d;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs

  assign awready = awvalid & wvalid & ~s_q.bvalid;
  assign wready = awvalid & wvalid & ~s_q.bvalid;
  assign bvalid = s_q.bvalid;
  assign bresp = s_q.bresp;
  assign arready = s_q.rst == sink_pkg::RD_IDLE;
  assign rvalid = s_q.rst == sink_pkg::RD_RESP;
  assign rdata = s_q.rdata;
  assign rresp = s_q.rresp;
  assign trail_fail_action = s_q.tsf;
  assign remote_defect_action = s_q.tsf;
  assign trail_degrade_action = s_q.deg;
  assign remote_error_action = s_q.rei;
  assign reported_trace_mismatch = s_q.rep[sink_pkg::EV_TIM];
  assign reported_unequipped = s_q.rep[sink_pkg::EV_UNEQ];
  assign reported_degrade = s_q.rep[sink_pkg::EV_DEG];
  assign reported_far_defect = s_q.rep[sink_pkg::EV_RDI];
  assign reported_server_fail = s_q.rep[sink_pkg::EV_SSF];
  assign irq = |(s_q.ist & s_q.imask);
endmodule
`default_nettype wire

// *** verification/sink_sva.sv ***
// Checker for the container sink: bus handshakes, actions and reports.
// Assumes it is bound to the sink top and sees only that module's ports.
`default_nettype none
module sink_sva (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic incoming_server_fail,
  input wire logic awvalid,
  input wire logic awready,
  input wire logic wvalid,
  input wire logic wready,
  input wire logic [1:0] bresp,
  input wire logic bvalid,
  input wire logic bready,
  input wire logic arvalid,
  input wire logic arready,
  input wire logic [31:0] rdata,
  input wire logic rvalid,
  input wire logic rready,
  input wire logic trail_fail_action,
  input wire logic remote_defect_action,
  input wire logic [1:0] remote_error_action,
  input wire logic reported_trace_mismatch,
  input wire logic reported_unequipped,
  input wire logic reported_degrade,
  input wire logic reported_far_defect
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  //////////////////////////////////////////////////////////////////////////
  chk_fail_pair: assert property (
    trail_fail_action == remote_defect_action)
    else $error("trail fail and remote defect differ");
  // Six cycles leave room for the two-stage synchroniser
  chk_ssf_fail: assert property (
    incoming_server_fail [*6] |-> trail_fail_action)
    else $error("server fail did not raise trail fail");
  chk_uneq_tim: assert property (
    reported_unequipped |-> !reported_trace_mismatch)
    else $error("unequipped and mismatch reported together");
  chk_uneq_fail: assert property (
    reported_unequipped |-> trail_fail_action || $past(trail_fail_action))
    else $error("unequipped reported without trail fail");
  chk_deg_tim: assert property (
    reported_degrade |-> !reported_trace_mismatch)
    else $error("degrade reported during mismatch");
  chk_far_tim: assert property (
    reported_far_defect |-> !reported_trace_mismatch && !reported_unequipped)
    else $error("far defect reported during mismatch");
  chk_rei_range: assert property (
    remote_error_action != 2'h3)
    else $error("more than two parity violations per frame");
  chk_w_answer: assert property (
    awvalid && awready && wvalid && wready |=> bvalid)
    else $error("write response late");
  chk_b_hold: assert property (
    bvalid && !bready |=> bvalid && $stable(bresp))
    else $error("write response dropped");
  chk_r_answer: assert property (
    arvalid && arready |-> ##2 rvalid)
    else $error("read data not two cycles after address");
  chk_r_hold: assert property (
    rvalid && !rready |=> rvalid && $stable(rdata))
    else $error("read data dropped");
endmodule
bind vc11_unequipped_sink sink_sva sink_sva_i (.*);
`default_nettype wire

// *** verification/link_src.sv ***
// Upstream framer model: sends container frames MSB first on the link.
// Assumes the caller passes V5 with bits 1-2 left for the parity.
`default_nettype none
module link_src #(
  parameter int NBYTES = 104
) (
  output logic ci_clk,
  output logic ci_data,
  output logic ci_frame_start
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [1:0] bip_q;
  initial
  begin
    ci_clk = 1'b0;
    ci_data = 1'b0;
    ci_frame_start = 1'b0;
    bip_q = 2'h0;
  end
  // Clock stands low between frames; data then shows the inverted last bit
  task automatic send_frame(input logic [7:0] v5, input logic [7:0] j2,
    input logic [1:0] flip);
    logic [7:0] b;
    logic [1:0] acc;
    acc = 2'h0;
    for (int i = 0; i < NBYTES; i++)
    begin
      b = 8'(i) * 8'h25;
      if (i == 0)
        b = {bip_q ^ flip, v5[5:0]};
      if (i == sink_pkg::J2_BYTE)
        b = j2;
      for (int k = 7; k >= 0; k--)
      begin
        ci_data <= b[k];
        ci_frame_start <= (i == 0) && (k == 7);
        #80 ci_clk <= 1'b1;
        #80 ci_clk <= 1'b0;
      end
      acc ^= {b[7] ^ b[5] ^ b[3] ^ b[1], b[6] ^ b[4] ^ b[2] ^ b[0]};
    end
    bip_q = acc;
    ci_data <= ~ci_data;
    ci_frame_start <= 1'b0;
    // Idle level stands a while, so the next frame never lands in this step
    #80;
  endtask
endmodule
`default_nettype wire

// *** verification/vc11_unequipped_sink_tb.sv ***
// Testbench for the container sink: registers, frames and actions.
// Assumes the framer model and the checker bind are compiled first.
`default_nettype none
module vc11_unequipped_sink_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic aclk, aresetn, ci_clk, ci_data, ci_frame_start, irq;
  logic incoming_server_fail, awvalid, awready, wvalid, wready, bvalid;
  logic bready, arvalid, arready, rvalid, rready;
  logic [7:0] awaddr, araddr;
  logic [31:0] wdata, rdata;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp, remote_error_action;
  logic trail_fail_action, trail_degrade_action, remote_defect_action;
  logic reported_trace_mismatch, reported_unequipped, reported_degrade;
  logic reported_far_defect, reported_server_fail;
  int miscompares, n_checks, n;
  // Short second window keeps the degrade logic reachable in a short run
  vc11_unequipped_sink #(.SEC_CYCLES(2000)) vc11_unequipped_sink_i (.*);
  // Short frames keep the run short; the parity covers what is sent
  link_src #(.NBYTES(28)) link_src_i (.ci_clk(ci_clk), .ci_data(ci_data),
    .ci_frame_start(ci_frame_start));
  //////////////////////////////////////////////////////////////////////////
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      miscompares++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d,
    input logic [1:0] er);
    logic ta, tw, tb, tv;
    int k;
    tb = 1'b0;
    k = 0;
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    // Ready is raised late so the response has to stand for a cycle
    while (!tb && k < 50)
    begin
      @(negedge aclk);
      ta = awvalid && awready;
      tw = wvalid && wready;
      tb = bvalid && bready;
      tv = bvalid;
      if (tb)
        cmp(32'(bresp), 32'(er));
      @(posedge aclk);
      if (ta)
        awvalid <= 1'b0;
      if (tw)
        wvalid <= 1'b0;
      bready <= tv && !tb;
      k++;
    end
    if (!tb)
    begin
      miscompares++;
      print_verdict();
    end
  endtask
  task automatic rdc(input logic [7:0] a, input logic [31:0] exp,
    input logic [1:0] er);
    logic ta, tr, tv;
    int k;
    tr = 1'b0;
    k = 0;
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    while (!tr && k < 50)
    begin
      @(negedge aclk);
      ta = arvalid && arready;
      tr = rvalid && rready;
      tv = rvalid;
      if (tr)
        cmp(rdata, exp);
      if (tr)
        cmp(32'(rresp), 32'(er));
      @(posedge aclk);
      if (ta)
        arvalid <= 1'b0;
      rready <= tv && !tr;
      k++;
    end
    if (!tr)
    begin
      miscompares++;
      print_verdict();
    end
  endtask
  // Sync, action and report stages together take well under this
  task automatic settle();
    repeat (12) @(posedge aclk);
  endtask
  //////////////////////////////////////////////////////////////////////////
  initial
  begin
    aclk = 1'b0;
    forever #10 aclk = ~aclk;
  end
  initial
  begin
    {aresetn, incoming_server_fail, awvalid, wvalid, bready} = 5'h00;
    {arvalid, rready, awaddr, araddr, wdata} = 50'h0;
    wstrb = 4'hF;
    miscompares = 0;
    n_checks = 0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    rdc(sink_pkg::REG_CTRL, 32'h0, sink_pkg::RESP_OKAY);
    rdc(sink_pkg::REG_DEG, 32'h0002_0010, sink_pkg::RESP_OKAY);
    rdc(sink_pkg::REG_INT_MASK, 32'h0, sink_pkg::RESP_OKAY);
    rdc(8'h20, 32'h0, sink_pkg::RESP_SLVERR);
    wr(8'h24, 32'hFFFF_FFFF, sink_pkg::RESP_SLVERR);
    for (int i = 0; i < 16; i++)
      wr(sink_pkg::TRACE_EXP_BASE + 8'(4 * i), 32'h0, sink_pkg::RESP_OKAY);
    wr(sink_pkg::REG_INT_MASK, 32'h1F, sink_pkg::RESP_OKAY);
    // One errored block makes a bad second; one bad second sets degrade
    wr(sink_pkg::REG_DEG, 32'h0001_0001, sink_pkg::RESP_OKAY);
    wr(sink_pkg::REG_CTRL, 32'h5, sink_pkg::RESP_OKAY);
    // Equipped label; second and third frames carry parity errors and REI
    link_src_i.send_frame(8'h02, 8'h00, 2'h0);
    link_src_i.send_frame(8'h22, 8'h00, 2'h3);
    cmp(32'(remote_error_action), 32'h2);
    link_src_i.send_frame(8'h22, 8'h00, 2'h1);
    cmp(32'(remote_error_action), 32'h1);
    cmp(32'(trail_degrade_action), 32'h1);
    cmp(32'(reported_degrade), 32'h1);
    link_src_i.send_frame(8'h02, 8'h00, 2'h0);
    cmp(32'(remote_error_action), 32'h0);
    rdc(sink_pkg::REG_NEAR_COUNT, 32'h2, sink_pkg::RESP_OKAY);
    rdc(sink_pkg::REG_NEAR_COUNT, 32'h0, sink_pkg::RESP_OKAY);
    rdc(sink_pkg::REG_FAR_COUNT, 32'h2, sink_pkg::RESP_OKAY);
    rdc(sink_pkg::REG_INT_STATUS, 32'h4, sink_pkg::RESP_OKAY);
    // All-zero label with remote defect, held past the persistence count
    repeat (6) link_src_i.send_frame(8'h01, 8'h00, 2'h0);
    cmp(32'(reported_far_defect), 32'h1);
    cmp(32'(reported_unequipped), 32'h0);
    cmp(32'(trail_fail_action), 32'h0);
    cmp(32'(remote_defect_action), 32'h0);
    cmp(32'(irq), 32'h1);
    rdc(sink_pkg::REG_INT_STATUS, 32'h8, sink_pkg::RESP_OKAY);
    cmp(32'(irq), 32'h0);
    wr(sink_pkg::REG_CTRL, 32'h1, sink_pkg::RESP_OKAY);
    settle();
    cmp(32'(reported_far_defect), 32'h0);
    wr(sink_pkg::REG_CTRL, 32'h3, sink_pkg::RESP_OKAY);
    @(posedge aclk);
    incoming_server_fail <= 1'b1;
    settle();
    cmp(32'(trail_fail_action), 32'h1);
    cmp(32'(remote_defect_action), 32'h1);
    cmp(32'(reported_server_fail), 32'h1);
    incoming_server_fail <= 1'b0;
    settle();
    cmp(32'(trail_fail_action), 32'h0);
    wr(sink_pkg::REG_CTRL, 32'h5, sink_pkg::RESP_OKAY);
    // Expected trace no longer matches the all-zero received trace
    wr(sink_pkg::TRACE_EXP_BASE, 32'h41, sink_pkg::RESP_OKAY);
    n = 0;
    while (trail_fail_action !== 1'b1 && n < 34)
    begin
      link_src_i.send_frame(8'h01, 8'h00, 2'h0);
      n++;
    end
    if (trail_fail_action !== 1'b1)
    begin
      miscompares++;
      print_verdict();
    end
    cmp(32'(remote_defect_action), 32'h1);
    cmp(32'(reported_unequipped), 32'h1);
    cmp(32'(reported_trace_mismatch), 32'h0);
    cmp(32'(reported_far_defect), 32'h0);
    rdc(sink_pkg::TRACE_ACC_BASE, 32'h0, sink_pkg::RESP_OKAY);
    repeat (6) link_src_i.send_frame(8'h02, 8'h00, 2'h0);
    cmp(32'(reported_trace_mismatch), 32'h1);
    cmp(32'(reported_unequipped), 32'h0);
    cmp(32'(trail_fail_action), 32'h1);
    print_verdict();
  end
endmodule
`default_nettype wire
